// ===== logic/ccw_dev.sv
// Device end: configuration word register and its decoded controls
`timescale 1ns/100ps
module ccw_dev
   import ccw_pkg::*;
#(
   parameter int DEC_W = 6
)
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   ccw_link_if.dev link,
   input wire logic input_sample_clock_en_i,
   input wire logic processing_clock_en_i,
   input wire logic external_sync_input_i,
   input wire logic back_end_reset_on_sync_i,
   input wire logic [2:0] gain_adjust_pins_i,
   input wire logic offset_freq_serial_data_i,
   input wire logic offset_freq_serial_frame_i,
   input wire logic [31:0] phase_hold_i,
   output ccw_pkg::ccw_word_t config_word_o,
   output logic offset_binary_o,
   output logic interpolated_mode_o,
   output logic [3:0] shift_total_o,
   output logic [5:0] dec_preload_o,
   output logic cic_bypass_o,
   output logic [5:0] dec_count_o,
   output logic cic_dump_o,
   output logic [1:0] ofs_width_o,
   output logic sync_out_proc_sel_o,
   output logic sync_out_en_o,
   output logic [31:0] center_freq_active_o,
   output logic [31:0] phase_active_o,
   output logic [31:0] nco_freq_o,
   output logic acc_feedback_zero_o,
   output logic front_back_reset_o
);
   import ccw_pkg::*;

   // Counter and preload ports are fixed at six bits
   if (DEC_W != 6)
   begin
      $error("DEC_W must be 6");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Master register assembly
   logic [31:0] mstr_q, mstr_d, cfg_q, cfg_d, fhold_q, fhold_d;
   logic [31:0] fact_q, fact_d, pact_q, pact_d;
   logic [5:0] dcnt_q, dcnt_d;
   logic [1:0] bidx_q, bidx_d;
   logic pend_q, pend_d, zfb_q, zfb_d, rst_q, rst_d, dump_q, dump_d;
   logic pph_q, pph_d;
   logic load_cfg, load_freq, xfer, sync_nco;
   logic [4:0] sg_sum;
   logic [31:0] ofs_word;

   // Bytes arrive LSB first; last strobe commits however many bytes came
   always_comb
   begin
      mstr_d = mstr_q;
      bidx_d = bidx_q;
      if (link.wr_stb)
      begin
         mstr_d[bidx_q*8 +: 8] = link.data;
         bidx_d = link.last ? 2'h0 : bidx_q + 2'h1;
         if (bidx_q == 2'h0)
            mstr_d[31:8] = 24'h0;
      end
   end

   // Loads happen on the last byte strobe with no sample clock gating; the host waits for it to run
   assign load_cfg = link.wr_stb && link.last && link.addr == CCW_ADDR_CFG;
   assign load_freq = link.wr_stb && link.last && link.addr == CCW_ADDR_FREQ;
   assign xfer = link.wr_stb && link.last && link.addr == CCW_ADDR_XFER;
   assign sync_nco = external_sync_input_i && cfg_q[CCW_NCO_SYNC_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Config word, holding and active registers
   always_comb
   begin
      cfg_d = cfg_q;
      fhold_d = fhold_q;
      fact_d = fact_q;
      pact_d = pact_q;
      pend_d = pend_q;
      pph_d = pph_q;
      zfb_d = 1'b0;
      if (load_cfg)
         cfg_d = mstr_d & ~CCW_RSVD_MASK;
      if (load_freq)
         fhold_d = mstr_d;
      if (xfer || sync_nco)
         pend_d = 1'b1;
      // Only a sync moves the phase; a transfer word moves frequency alone
      if (sync_nco)
         pph_d = 1'b1;
      // Sync seen between sample ticks is held until the next tick
      if (input_sample_clock_en_i && (pend_q || xfer || sync_nco))
      begin
         fact_d = fhold_q;
         if (sync_nco || pph_q)
            pact_d = phase_hold_i;
         pend_d = 1'b0;
         pph_d = 1'b0;
         zfb_d = cfg_q[CCW_LDPH_BIT];
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         mstr_q <= 32'h0;
         bidx_q <= 2'h0;
         cfg_q <= CCW_CFG_RESET;
         fhold_q <= 32'h0;
         fact_q <= 32'h0;
         pact_q <= 32'h0;
         pend_q <= 1'b0;
         pph_q <= 1'b0;
         zfb_q <= 1'b0;
      end
      else
      begin
         mstr_q <= mstr_d;
         bidx_q <= bidx_d;
         cfg_q <= cfg_d;
         fhold_q <= fhold_d;
         fact_q <= fact_d;
         pact_q <= pact_d;
         pend_q <= pend_d;
         pph_q <= pph_d;
         zfb_q <= zfb_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decimation counter and sync reset
   always_comb
   begin
      dcnt_d = dcnt_q;
      dump_d = 1'b0;
      rst_d = external_sync_input_i && back_end_reset_on_sync_i;
      if (external_sync_input_i && cfg_q[CCW_CIC_SYNC_BIT])
         dcnt_d = cfg_q[CCW_DEC_HI:CCW_DEC_LO];
      else if (input_sample_clock_en_i && !cfg_q[CCW_BYP_BIT])
      begin
         if (dcnt_q == 6'h0)
         begin
            dcnt_d = cfg_q[CCW_DEC_HI:CCW_DEC_LO];
            dump_d = 1'b1;
         end
         else
            dcnt_d = dcnt_q - 6'h1;
      end
      if (cfg_q[CCW_BYP_BIT])
         dump_d = input_sample_clock_en_i;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         dcnt_q <= CCW_DEC_RESET;
         dump_q <= 1'b0;
         rst_q <= 1'b0;
      end
      else
      begin
         dcnt_q <= dcnt_d;
         dump_q <= dump_d;
         rst_q <= rst_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial offset frequency
   ccw_ofs_rx u_ofs
   (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .width_code_i(cfg_q[CCW_OFSW_HI:CCW_OFSW_LO]),
      .offset_freq_serial_data_i(offset_freq_serial_data_i),
      .offset_freq_serial_frame_i(offset_freq_serial_frame_i),
      .offset_word_o(ofs_word),
      .offset_valid_o()
   );

   assign sg_sum = {1'b0, cfg_q[CCW_SG_HI:CCW_SG_LO]} + {2'h0, gain_adjust_pins_i};

   assign config_word_o = cfg_q;
   assign offset_binary_o = cfg_q[CCW_FMT_BIT];
   assign interpolated_mode_o = cfg_q[CCW_MODE_BIT];
   assign shift_total_o = sg_sum[4] ? CCW_SG_MAX : sg_sum[3:0];
   assign dec_preload_o = cfg_q[CCW_DEC_HI:CCW_DEC_LO];
   assign cic_bypass_o = cfg_q[CCW_BYP_BIT];
   assign dec_count_o = dcnt_q;
   assign cic_dump_o = dump_q;
   assign ofs_width_o = cfg_q[CCW_OFSW_HI:CCW_OFSW_LO];
   assign sync_out_proc_sel_o = cfg_q[CCW_SYNCCLK_BIT];
   assign sync_out_en_o = cfg_q[CCW_SYNCCLK_BIT] ? processing_clock_en_i
                                                 : input_sample_clock_en_i;
   assign center_freq_active_o = fact_q;
   assign phase_active_o = pact_q;
   assign nco_freq_o = cfg_q[CCW_OFSEN_BIT] ? fact_q + ofs_word : fact_q;
   assign acc_feedback_zero_o = cfg_q[CCW_CLRPH_BIT] | zfb_q;
   assign front_back_reset_o = rst_q;
endmodule

// ===== logic/ccw_pkg.sv
// Package: control word field layout, codes and limits for the config word block
package ccw_pkg;
   localparam int CCW_WORD_W = 32;
   localparam int CCW_BYTE_W = 8;
   localparam int CCW_NBYTES = 4;
   localparam int CCW_ADDR_W = 3;
   // Master register destination addresses
   localparam logic [2:0] CCW_ADDR_CFG = 3'h0;
   localparam logic [2:0] CCW_ADDR_FREQ = 3'h3;
   localparam logic [2:0] CCW_ADDR_XFER = 3'h5;
   // Field positions inside the configuration word
   localparam int CCW_NCO_SYNC_BIT = 20;
   localparam int CCW_CIC_SYNC_BIT = 19;
   localparam int CCW_FMT_BIT = 18;
   localparam int CCW_MODE_BIT = 17;
   localparam int CCW_SG_HI = 16;
   localparam int CCW_SG_LO = 13;
   localparam int CCW_DEC_HI = 12;
   localparam int CCW_DEC_LO = 7;
   localparam int CCW_BYP_BIT = 6;
   localparam int CCW_OFSW_HI = 5;
   localparam int CCW_OFSW_LO = 4;
   localparam int CCW_SYNCCLK_BIT = 3;
   localparam int CCW_CLRPH_BIT = 2;
   localparam int CCW_OFSEN_BIT = 1;
   localparam int CCW_LDPH_BIT = 0;
   localparam int CCW_RSVD_LO = 21;
   localparam int CCW_BE_RST_BIT = 22;
   localparam logic [31:0] CCW_CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] CCW_RSVD_MASK = 32'hFFE0_0000;
   localparam logic [3:0] CCW_SG_MAX = 4'hF;
   localparam logic [5:0] CCW_DEC_MIN = 6'h03;
   localparam logic [5:0] CCW_DEC_MAX = 6'h1F;
   localparam logic [5:0] CCW_DEC_RESET = 6'h03;
   localparam int CCW_BUS_DIV = 2;
   typedef logic [31:0] ccw_word_t;

   // Serial offset word length from the width field
   function automatic logic [5:0] ccw_ofs_len(input logic [1:0] code);
      // Three-bit sum so that code 3 gives 32, not a wrapped 0
      ccw_ofs_len = {{1'b0, code} + 3'h1, 3'h0};
   endfunction
endpackage

// ===== logic/ccw_link_if.sv
// Interface: byte-wide master register write port between host and device
`timescale 1ns/100ps
interface ccw_link_if;
   logic [7:0] data;
   logic [2:0] addr;
   logic wr_stb;
   logic last;
   modport host (output data, output addr, output wr_stb, output last);
   modport dev (input data, input addr, input wr_stb, input last);
endinterface

// ===== logic/ccw_ofs_rx.sv
// Serial offset frequency receiver with programmable word length
`timescale 1ns/100ps
module ccw_ofs_rx
   import ccw_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic [1:0] width_code_i,
   input wire logic offset_freq_serial_data_i,
   input wire logic offset_freq_serial_frame_i,
   output logic [31:0] offset_word_o,
   output logic offset_valid_o
);
   import ccw_pkg::*;
   logic [31:0] sh_q, sh_d, word_q, word_d;
   logic [5:0] cnt_q, cnt_d;
   logic busy_q, busy_d, vld_q, vld_d;

   // Frame marks the first bit, MSB first
   always_comb
   begin
      sh_d = sh_q;
      cnt_d = cnt_q;
      busy_d = busy_q;
      word_d = word_q;
      vld_d = 1'b0;
      if (offset_freq_serial_frame_i)
      begin
         sh_d = {31'h0, offset_freq_serial_data_i};
         cnt_d = 6'h1;
         busy_d = 1'b1;
      end
      else if (busy_q)
      begin
         sh_d = {sh_q[30:0], offset_freq_serial_data_i};
         cnt_d = cnt_q + 6'h1;
      end
      if (busy_q && cnt_q == ccw_ofs_len(width_code_i))
      begin
         // Short words are placed in the top bits, scaled like the 32-bit word
         word_d = sh_q << (6'd32 - ccw_ofs_len(width_code_i));
         vld_d = 1'b1;
         if (!offset_freq_serial_frame_i)
            busy_d = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         sh_q <= 32'h0;
         cnt_q <= 6'h0;
         busy_q <= 1'b0;
         word_q <= 32'h0;
         vld_q <= 1'b0;
      end
      else
      begin
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         word_q <= word_d;
         vld_q <= vld_d;
      end
   end

   assign offset_word_o = word_q;
   assign offset_valid_o = vld_q;
endmodule

// ===== logic/ccw_host.sv
// Host end: splits a word into master register byte writes
`timescale 1ns/100ps
module ccw_host
   import ccw_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic req_i,
   input wire logic [2:0] req_addr_i,
   input wire logic [31:0] req_data_i,
   input wire logic req_short_i,
   input wire logic sample_clock_running_i,
   output logic busy_o,
   output logic done_o,
   ccw_link_if.host link
);
   import ccw_pkg::*;
   typedef enum logic [1:0] {CCW_IDLE, CCW_SEND} ccw_hst_t;
   ccw_hst_t st_q, st_d;
   logic [31:0] dat_q, dat_d;
   logic [2:0] adr_q, adr_d;
   logic [1:0] idx_q, idx_d, nb_q, nb_d;
   logic done_q, done_d;

   always_comb
   begin
      st_d = st_q;
      dat_d = dat_q;
      adr_d = adr_q;
      idx_d = idx_q;
      nb_d = nb_q;
      done_d = 1'b0;
      case (st_q)
         CCW_IDLE:
         begin
            // Wait for the sample clock so the load is not lost
            if (req_i && sample_clock_running_i)
            begin
               // Config word gets its reserved bits cleared
               dat_d = (req_addr_i == CCW_ADDR_CFG) ? req_data_i & ~CCW_RSVD_MASK
                                                    : req_data_i;
               adr_d = req_addr_i;
               idx_d = 2'h0;
               nb_d = req_short_i ? 2'h1 : 2'h3;
               st_d = CCW_SEND;
            end
         end
         CCW_SEND:
         begin
            idx_d = idx_q + 2'h1;
            if (idx_q == nb_q)
            begin
               st_d = CCW_IDLE;
               done_d = 1'b1;
            end
         end
         default:
            st_d = CCW_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         st_q <= CCW_IDLE;
         dat_q <= 32'h0;
         adr_q <= 3'h0;
         idx_q <= 2'h0;
         nb_q <= 2'h0;
         done_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         dat_q <= dat_d;
         adr_q <= adr_d;
         idx_q <= idx_d;
         nb_q <= nb_d;
         done_q <= done_d;
      end
   end

   assign link.wr_stb = (st_q == CCW_SEND);
   assign link.data = dat_q[idx_q*8 +: 8];
   assign link.addr = adr_q;
   assign link.last = (st_q == CCW_SEND) && (idx_q == nb_q);
   assign busy_o = (st_q != CCW_IDLE);
   assign done_o = done_q;
endmodule

// ===== testbench/ccw_link_monitor.sv
// Checker: framing properties of the master register write port
`timescale 1ns/100ps
module ccw_link_monitor
   import ccw_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] data,
   input wire logic [2:0] addr,
   input wire logic wr_stb,
   input wire logic last
);
   import ccw_pkg::*;
   logic [2:0] idx_q;
   logic [2:0] idx_d;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);
   ////////////////////////////////////////////////////////////////
   // Byte index inside the word on the wire
   always_comb
   begin
      idx_d = idx_q;
      if (wr_stb)
      begin
         idx_d = last ? 3'h0 : idx_q + 3'h1;
      end
   end
   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         idx_q <= 3'h0;
      end
      else
      begin
         idx_q <= idx_d;
      end
   end
   ////////////////////////////////////////////////////////////////
   sequence two_bytes;
      wr_stb ##1 wr_stb;
   endsequence
   sequence word_end;
      wr_stb && last;
   endsequence
   last_with_stb_a: assert property (last |-> wr_stb)
      else $error("last seen without a byte strobe");
   min_two_a: assert property ($rose(wr_stb) |-> two_bytes)
      else $error("word shorter than two bytes");
   back_to_back_a: assert property (wr_stb && !last |=> wr_stb)
      else $error("gap inside a word");
   gap_after_a: assert property (word_end |=> !wr_stb)
      else $error("next word without a gap");
   addr_hold_a: assert property (wr_stb && !last |=> $stable(addr))
      else $error("address changed inside a word");
   word_len_a: assert property (word_end |-> idx_q == 3'h1 || idx_q == 3'h3)
      else $error("word not two or four bytes");
   rsvd_third_a: assert property (wr_stb && addr == CCW_ADDR_CFG && idx_q == 3'h2
      |-> data[7:5] == 3'h0)
      else $error("reserved bits set in third byte");
   rsvd_fourth_a: assert property (wr_stb && addr == CCW_ADDR_CFG && idx_q == 3'h3
      |-> data == 8'h00)
      else $error("reserved bits set in fourth byte");
endmodule

// ===== testbench/chip_config_input_cic_control_bench.sv
// Testbench: host and device ends joined over the write port
`timescale 1ns/100ps
module chip_config_input_cic_control_bench;
   import ccw_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic req = 1'b0, shrt = 1'b0, run = 1'b1, se = 1'b0, pe = 1'b1, sync = 1'b0, ber = 1'b0;
   logic [2:0] ra = 3'h0, gp = 3'h0;
   logic [31:0] rd = 32'h0, ph = 32'h0;
   logic busy, done, ofsb, intp, byp, selp, soe, fz, fbr, dmp;
   logic sdat = 1'b0, sfrm = 1'b0;
   logic [3:0] sh;
   logic [5:0] pre, dcnt;
   logic [1:0] ow;
   logic [31:0] cfg, cfa, pha, nco;
   int error_cnt = 0;
   int num_checks = 0;
   always #5 clk = ~clk;
   ccw_link_if link();
   ccw_host u_ccw_host (.core_clk_i(clk), .nrst_i(nrst), .req_i(req), .req_addr_i(ra),
      .req_data_i(rd), .req_short_i(shrt), .sample_clock_running_i(run), .busy_o(busy),
      .done_o(done), .link(link.host));
   ccw_dev u_ccw_dev (.core_clk_i(clk), .nrst_i(nrst), .link(link.dev),
      .input_sample_clock_en_i(se), .processing_clock_en_i(pe), .external_sync_input_i(sync),
      .back_end_reset_on_sync_i(ber), .gain_adjust_pins_i(gp), .offset_freq_serial_data_i(sdat),
      .offset_freq_serial_frame_i(sfrm), .phase_hold_i(ph), .config_word_o(cfg),
      .offset_binary_o(ofsb), .interpolated_mode_o(intp), .shift_total_o(sh),
      .dec_preload_o(pre), .cic_bypass_o(byp), .dec_count_o(dcnt), .cic_dump_o(dmp),
      .ofs_width_o(ow), .sync_out_proc_sel_o(selp), .sync_out_en_o(soe),
      .center_freq_active_o(cfa), .phase_active_o(pha), .nco_freq_o(nco),
      .acc_feedback_zero_o(fz), .front_back_reset_o(fbr));
   ccw_link_monitor u_ccw_link_monitor (.core_clk_i(clk), .nrst_i(nrst), .data(link.data),
      .addr(link.addr), .wr_stb(link.wr_stb), .last(link.last));
   ////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Request on a falling edge, wait for done under a bound
   task automatic send(input logic [2:0] a, input logic [31:0] d, input logic s);
      int i;
      req = 1'b1; ra = a; rd = d; shrt = s;
      @(negedge clk);
      req = 1'b0;
      for (i = 0; i < 20 && done !== 1'b1; i++)
         @(negedge clk);
      if (done !== 1'b1)
      begin
         chk(1'b0, 1'b1);
         report_and_stop();
      end
      @(negedge clk);
   endtask
   task automatic pulse_sync();
      sync = 1'b1;
      @(negedge clk);
      sync = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_cfg(input logic [31:0] w, input logic [2:0] g);
      logic [4:0] sum;
      gp = g;
      send(CCW_ADDR_CFG, w, 1'b0);
      sum = w[CCW_SG_HI:CCW_SG_LO] + g;
      chk(cfg, w & ~CCW_RSVD_MASK);
      chk(ofsb, w[CCW_FMT_BIT]);
      chk(intp, w[CCW_MODE_BIT]);
      chk(sh, sum > 5'd15 ? 4'hF : sum[3:0]);
      chk(pre, w[CCW_DEC_HI:CCW_DEC_LO]);
      chk(byp, w[CCW_BYP_BIT]);
      chk(ow, w[CCW_OFSW_HI:CCW_OFSW_LO]);
      chk(selp, w[CCW_SYNCCLK_BIT]);
      chk(soe, w[CCW_SYNCCLK_BIT]);
      chk(fz, w[CCW_CLRPH_BIT]);
   endtask
   // A request with the sample clock stopped must be left waiting
   task automatic t_short();
      run = 1'b0;
      req = 1'b1;
      ra = CCW_ADDR_CFG;
      shrt = 1'b1;
      @(negedge clk);
      req = 1'b0;
      chk(busy, 1'b0);
      run = 1'b1;
      send(CCW_ADDR_CFG, 32'hFFFF_0A34, 1'b1);
      chk(cfg, 32'h0000_0A34);
   endtask
   // Sync meets a sample tick, so the NCO load is not held back
   task automatic t_sync();
      send(CCW_ADDR_CFG, 32'h0018_0381, 1'b0);
      ph = 32'h1357_9BDF;
      ber = 1'b1;
      se = 1'b1;
      pulse_sync();
      se = 1'b0;
      chk(pha, 32'h1357_9BDF);
      chk(dcnt, 6'h07);
      chk(fbr, 1'b1);
      chk(fz, 1'b1);
      send(CCW_ADDR_CFG, 32'h0000_0500, 1'b0);
      ph = 32'h2468_ACE0;
      ber = 1'b0;
      se = 1'b1;
      pulse_sync();
      se = 1'b0;
      chk(pha, 32'h1357_9BDF);
      // Tick counts down from 7; the sync must not reload 10
      chk(dcnt, 6'h06);
      chk(fbr, 1'b0);
      chk(fz, 1'b0);
   endtask
   task automatic t_xfer();
      send(CCW_ADDR_FREQ, 32'hC0DE_F00D, 1'b0);
      chk(cfa, 32'h0);
      send(CCW_ADDR_XFER, 32'h0, 1'b1);
      chk(cfa, 32'h0);
      se = 1'b1;
      @(negedge clk);
      se = 1'b0;
      @(negedge clk);
      chk(cfa, 32'hC0DE_F00D);
      chk(pha, 32'h1357_9BDF);
      chk(nco, 32'hC0DE_F00D);
   endtask
   // Serial offset word, MSB first, frame high with the first bit
   task automatic shift_ofs(input logic [31:0] v, input int n);
      int i;
      for (i = n - 1; i >= 0; i--)
      begin
         sfrm = (i == n - 1);
         sdat = v[i];
         @(negedge clk);
      end
      sfrm = 1'b0;
      sdat = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task automatic t_offset();
      send(CCW_ADDR_CFG, 32'h0000_0182, 1'b0);
      shift_ofs(32'h0000_00A5, 8);
      chk(nco, 32'hC0DE_F00D + 32'hA500_0000);
      send(CCW_ADDR_CFG, 32'h0000_01B2, 1'b0);
      shift_ofs(32'h1234_5678, 32);
      chk(nco, 32'hC0DE_F00D + 32'h1234_5678);
   endtask
   // Bypass dumps on every tick; otherwise once per four ticks at R of 4
   task automatic t_dump();
      int i;
      send(CCW_ADDR_CFG, 32'h0000_01C0, 1'b0);
      for (i = 0; i < 2; i++)
      begin
         se = 1'b1;
         @(negedge clk);
         se = 1'b0;
         chk(dmp, 1'b1);
         @(negedge clk);
         chk(dmp, 1'b0);
      end
      send(CCW_ADDR_CFG, 32'h0008_0180, 1'b0);
      pulse_sync();
      chk(dcnt, 6'h03);
      for (i = 1; i <= 4; i++)
      begin
         se = 1'b1;
         @(negedge clk);
         se = 1'b0;
         chk(dmp, i == 4);
         @(negedge clk);
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      t_cfg(32'hFFFF_E1FF, 3'h7);
      t_cfg(32'h0002_A394, 3'h3);
      t_cfg(32'h0004_0180, 3'h0);
      t_short();
      t_sync();
      t_xfer();
      t_offset();
      t_dump();
      report_and_stop();
   end
endmodule
